//--- common/acc_pkg.sv
// Package for the analog comparator control block: offsets, fields, resets
package acc_pkg;
	localparam int          ACC_NUM_CMP        = 3;
	localparam logic [3:0]  ACC_ADDR_CMP1      = 4'h0;
	localparam logic [3:0]  ACC_ADDR_CMP2      = 4'h4;
	localparam logic [3:0]  ACC_ADDR_CMP3      = 4'h8;
	localparam logic [3:0]  ACC_ADDR_STAT      = 4'hC;
	localparam logic [3:0]  ACC_ADDR_REF       = 4'hD;
	// Comparator control fields
	localparam int          ACC_CC_ON          = 15;
	localparam int          ACC_CC_OE          = 14;
	localparam int          ACC_CC_INV         = 13;
	localparam int          ACC_CC_LVL         = 8;
	localparam int          ACC_CC_EV_LO       = 6;
	localparam int          ACC_CC_POS         = 4;
	localparam int          ACC_CC_NEG_LO      = 0;
	localparam logic [31:0] ACC_CC_WMASK       = 32'h0000_E0D3;
	localparam logic [31:0] ACC_CC_RESET       = 32'h0000_00C3;
	// Status fields
	localparam int          ACC_ST_IDLE        = 13;
	localparam logic [31:0] ACC_ST_WMASK       = 32'h0000_2000;
	// Reference fields
	localparam int          ACC_RF_ON          = 15;
	localparam int          ACC_RF_OE          = 6;
	localparam int          ACC_RF_RANGE       = 5;
	localparam int          ACC_RF_SRC         = 4;
	localparam int          ACC_RF_VAL_LO      = 0;
	localparam logic [31:0] ACC_RF_WMASK       = 32'h0000_807F;
	localparam logic [31:0] ACC_RF_RESET       = 32'h0000_0000;
	localparam logic [1:0]  ACC_EV_OFF         = 2'h0;
	localparam logic [1:0]  ACC_EV_RISE        = 2'h1;
	localparam logic [1:0]  ACC_EV_FALL        = 2'h2;
	localparam logic [1:0]  ACC_EV_BOTH        = 2'h3;

	typedef struct packed {
		logic       power_on;
		logic       pos_from_reference;
		logic [1:0] negative_input_select;
	} acc_analog_ctl_type;

	typedef struct packed {
		logic       power_on;
		logic       pin_enable;
		logic       range_select;
		logic       source_select;
		logic [3:0] level_value;
	} acc_ref_ctl_type;
endpackage

//--- rtl/acc_top.sv
// Control and status logic for three comparators and their reference ladder
// How it works
// - Enable bit powers comparator, other fields kept
// - Output enable drives result pin
// - Inversion bit flips the result
// - Inversion also feeds the event detector
// - Read-only level bit shows output, reset zero
// - Two-bit edge select for events, reset 11
// - Positive input: reference or pin A
// - Negative select B, C, D, absolute reference
// - Unimplemented bits read zero, ignore writes
// - Stop-in-idle disables all comparators when idle
// - Status shows three output levels, bits 0-2
// - Reference: two ranges, sixteen levels
// - Reference enable bit powers the ladder
// - Source select: supply rails or external
// - Reference always internal, pin optional
// - Pin enable connects reference to pin
// - Range bit picks scale and step
`timescale 1ns/1ns
`default_nettype none

// Two-flop synchroniser for levels from outside this clock
module acc_sync
	import acc_pkg::*;
#(
	parameter int WIDTH = 1
)(
	input  wire logic             core_clk_in,  // Peripheral clock
	input  wire logic             resetn_in,    // Sync reset, low
	input  wire logic [WIDTH-1:0] async_in,     // Asynchronous level
	output logic      [WIDTH-1:0] sync_out      // Synchronised level
);
	logic [WIDTH-1:0] meta_q;

	// Only the second stage is read; the first may be metastable
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// Edge detector on the sampled, possibly inverted result level
module acc_edge_event
	import acc_pkg::*;
(
	input  wire logic       core_clk_in,  // Peripheral clock
	input  wire logic       resetn_in,    // Sync reset, low
	input  wire logic       level_in,     // Sampled result level
	input  wire logic [1:0] select_in,    // Edge select field
	output logic            event_out     // One-cycle event pulse
);
	logic prev_q;
	logic rise;
	logic fall;

	assign rise = level_in & ~prev_q;
	assign fall = ~level_in & prev_q;

	// Reset value equals the forced-low level, so no false edge
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= level_in;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			event_out <= 1'b0;
		end else begin
			case (select_in)
				ACC_EV_OFF:  event_out <= 1'b0;
				ACC_EV_RISE: event_out <= rise;
				ACC_EV_FALL: event_out <= fall;
				ACC_EV_BOTH: event_out <= rise | fall;
				default:     event_out <= 1'b0;
			endcase
		end
	end
endmodule

// Reference ladder control register and its steering outputs
module acc_ref_ctl
	import acc_pkg::*;
(
	input  wire logic           core_clk_in,  // Peripheral clock
	input  wire logic           resetn_in,    // Sync reset, low
	input  wire logic           wr_in,        // Write to this register
	input  wire logic [31:0]    wdata_in,     // Write data
	output logic      [31:0]    reg_out,      // Register readback
	output var acc_ref_ctl_type ctl_out       // Ladder control
);
	logic [31:0] reg_q;

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			reg_q <= ACC_RF_RESET;
		end else if (wr_in) begin
			reg_q <= wdata_in & ACC_RF_WMASK;
		end
	end

	// Reference stays on internally whenever powered; pin is extra
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			ctl_out <= '0;
		end else begin
			ctl_out.power_on      <= reg_q[ACC_RF_ON];
			ctl_out.pin_enable    <= reg_q[ACC_RF_OE];
			ctl_out.range_select  <= reg_q[ACC_RF_RANGE];
			ctl_out.source_select <= reg_q[ACC_RF_SRC];
			ctl_out.level_value   <= reg_q[ACC_RF_VAL_LO +: 4];
		end
	end

	assign reg_out = reg_q;
endmodule

module acc_slice
	import acc_pkg::*;
(
	input  wire logic        core_clk_in,           // Peripheral clock
	input  wire logic        resetn_in,             // Sync reset, low
	input  wire logic        wr_in,                 // Write to this slice
	input  wire logic [31:0] wdata_in,              // Write data
	input  wire logic        raw_in,                // Synchronised raw result
	input  wire logic        idle_stop_in,          // Idle stop in force
	output logic      [31:0] ctl_out,               // Control readback
	output logic             level_out,             // Result level
	output logic             pin_out,               // Result pin value
	output logic             pin_oe_out,            // Result pin enable
	output logic             event_out,             // Event pulse
	output acc_analog_ctl_type analog_out           // Analog steering
);
	logic [31:0] ctl_q;
	logic        level_q;
	logic        active;
	logic        level_d;

	assign active  = ctl_q[ACC_CC_ON] & ~idle_stop_in;
	assign level_d = active & (raw_in ^ ctl_q[ACC_CC_INV]);

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			ctl_q <= ACC_CC_RESET;
		end else if (wr_in) begin
			ctl_q <= wdata_in & ACC_CC_WMASK;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			level_q    <= 1'b0;
			pin_out    <= 1'b0;
			pin_oe_out <= 1'b0;
		end else begin
			level_q    <= level_d;
			pin_out    <= level_d;
			pin_oe_out <= ctl_q[ACC_CC_OE] & active;
		end
	end

	// Events follow the inverted level, so inversion swaps edges
	acc_edge_event acc_edge_event_inst (
		.core_clk_in (core_clk_in),
		.resetn_in   (resetn_in),
		.level_in    (level_q),
		.select_in   (ctl_q[ACC_CC_EV_LO +: 2]),
		.event_out   (event_out)
	);

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			analog_out <= '{
				power_on:              1'b0,
				pos_from_reference:    1'b0,
				negative_input_select: ACC_CC_RESET[ACC_CC_NEG_LO +: 2]
			};
		end else begin
			analog_out.power_on <= active;
			analog_out.pos_from_reference <= ctl_q[ACC_CC_POS];
			analog_out.negative_input_select <=
				ctl_q[ACC_CC_NEG_LO +: 2];
		end
	end

	always_comb begin
		ctl_out = ctl_q;
		ctl_out[ACC_CC_LVL] = level_q;
	end
	assign level_out = level_q;
endmodule

module acc_top
	import acc_pkg::*;
#(
	parameter int NUM_CMP = ACC_NUM_CMP
)(
	input  wire logic               core_clk_in,    // 100 MHz clock
	input  wire logic               resetn_in,      // Sync reset, low
	input  wire logic [3:0]         addr_in,        // Register address
	input  wire logic [31:0]        wdata_in,       // Write data
	input  wire logic               wr_in,          // Write strobe
	input  wire logic               rd_in,          // Read strobe
	input  wire logic               idle_in,        // Device idle mode
	input  wire logic [NUM_CMP-1:0] raw_in,         // Analog raw results
	output logic      [31:0]        rdata_out,      // Read data
	output logic      [NUM_CMP-1:0] result_pin_out, // Result pin values
	output logic      [NUM_CMP-1:0] result_pin_oe_out, // Pin enables
	output logic      [NUM_CMP-1:0] event_out,      // Event pulses
	output acc_analog_ctl_type [NUM_CMP-1:0] analog_out, // Input steering
	output acc_ref_ctl_type         ref_ctl_out     // Ladder control
);
	localparam logic [3:0] CMP_STRIDE = ACC_ADDR_CMP2 - ACC_ADDR_CMP1;

	logic [NUM_CMP-1:0] raw_sync;
	logic [NUM_CMP-1:0] cmp_sel;
	logic [NUM_CMP-1:0] cmp_wr;
	logic [31:0]        stat_q;
	logic [31:0]        ref_rd;
	logic               idle_stop;
	logic [NUM_CMP-1:0] level;
	logic [31:0]        ctl_rd [NUM_CMP];
	logic [31:0]        ctl_mux;

	// Raw results are asynchronous to this clock
	acc_sync #(
		.WIDTH (NUM_CMP)
	) acc_sync_inst (
		.core_clk_in (core_clk_in),
		.resetn_in   (resetn_in),
		.async_in    (raw_in),
		.sync_out    (raw_sync)
	);

	// Slice j answers at the first control address plus j strides
	always_comb begin
		cmp_sel = '0;
		cmp_wr  = '0;
		for (int j = 0; j < NUM_CMP; j++) begin
			cmp_sel[j] = addr_in == 4'(ACC_ADDR_CMP1 + 4'(j) * CMP_STRIDE);
			cmp_wr[j]  = wr_in && cmp_sel[j];
		end
	end

	assign idle_stop = stat_q[ACC_ST_IDLE] & idle_in;

	for (genvar i = 0; i < NUM_CMP; i++) begin : g_slice
		acc_slice acc_slice_inst (
			.core_clk_in  (core_clk_in),
			.resetn_in    (resetn_in),
			.wr_in        (cmp_wr[i]),
			.wdata_in     (wdata_in),
			.raw_in       (raw_sync[i]),
			.idle_stop_in (idle_stop),
			.ctl_out      (ctl_rd[i]),
			.level_out    (level[i]),
			.pin_out      (result_pin_out[i]),
			.pin_oe_out   (result_pin_oe_out[i]),
			.event_out    (event_out[i]),
			.analog_out   (analog_out[i])
		);
	end

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			stat_q <= '0;
		end else if (wr_in && addr_in == ACC_ADDR_STAT) begin
			stat_q <= wdata_in & ACC_ST_WMASK;
		end
	end

	acc_ref_ctl acc_ref_ctl_inst (
		.core_clk_in (core_clk_in),
		.resetn_in   (resetn_in),
		.wr_in       (wr_in && addr_in == ACC_ADDR_REF),
		.wdata_in    (wdata_in),
		.reg_out     (ref_rd),
		.ctl_out     (ref_ctl_out)
	);

	// Address match is one-hot, so an OR of masked words suffices
	always_comb begin
		ctl_mux = '0;
		for (int j = 0; j < NUM_CMP; j++) begin
			ctl_mux = ctl_mux | (ctl_rd[j] & {32{cmp_sel[j]}});
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			rdata_out <= '0;
		end else if (rd_in && |cmp_sel) begin
			rdata_out <= ctl_mux;
		end else if (rd_in) begin
			case (addr_in)
				ACC_ADDR_STAT: rdata_out <= stat_q |
					32'(level);
				ACC_ADDR_REF:  rdata_out <= ref_rd;
				default:       rdata_out <= '0;
			endcase
		end else begin
			rdata_out <= '0;
		end
	end
endmodule

`default_nettype wire

//--- verification/acc_top_chk.sv
// Port assertions for the comparator control block
`timescale 1ns/1ns
`default_nettype none
module acc_top_chk
	import acc_pkg::*;
#(
	parameter int NUM_CMP = ACC_NUM_CMP
)(
	input wire logic                          core_clk_in,       // Clock
	input wire logic                          resetn_in,         // Reset
	input wire logic [3:0]                    addr_in,           // Address
	input wire logic [31:0]                   wdata_in,          // Wdata
	input wire logic                          wr_in,             // Write
	input wire logic                          rd_in,             // Read
	input wire logic                          idle_in,           // Idle
	input wire logic [NUM_CMP-1:0]            raw_in,            // Raw
	input wire logic [31:0]                   rdata_out,         // Rdata
	input wire logic [NUM_CMP-1:0]            result_pin_out,    // Pins
	input wire logic [NUM_CMP-1:0]            result_pin_oe_out, // Enables
	input wire logic [NUM_CMP-1:0]            event_out,         // Events
	input wire acc_analog_ctl_type [NUM_CMP-1:0] analog_out,     // Steering
	input wire acc_ref_ctl_type               ref_ctl_out        // Ladder
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);
	logic w1;
	logic wref;
	logic stop_in_idle_q;
	assign w1 = wr_in && addr_in == ACC_ADDR_CMP1;
	assign wref = wr_in && addr_in == ACC_ADDR_REF;
	// Shadow of stop-in-idle, the ports alone do not show it
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) stop_in_idle_q <= 1'b0;
		else if (wr_in && addr_in == ACC_ADDR_STAT)
			stop_in_idle_q <= wdata_in[ACC_ST_IDLE];
	end
	// Register lands one edge after the write, the output one more
	AST_OFF: assert property (w1 && !wdata_in[15] |-> ##2
		!analog_out[0].power_on)
		else $error("comparator one still powered");
	AST_NEG: assert property (w1 |-> ##2
		analog_out[0].negative_input_select == $past(wdata_in[1:0], 2))
		else $error("negative select wrong");
	AST_POS: assert property (w1 |-> ##2
		analog_out[0].pos_from_reference == $past(wdata_in[4], 2))
		else $error("positive select wrong");
	AST_REF: assert property (wref |-> ##2
		ref_ctl_out == {$past(wdata_in[15], 2), $past(wdata_in[6:0], 2)})
		else $error("ladder control wrong");
	AST_PIN_OFF: assert property (!analog_out[0].power_on |-> !result_pin_oe_out[0] && !result_pin_out[0])
		else $error("pin driven while off");
	AST_UNMAP: assert property (rd_in && addr_in == 4'h1 |=> rdata_out == 32'h0)
		else $error("unmapped read not zero");
	AST_CTL_RSV: assert property (rd_in && addr_in == ACC_ADDR_CMP1 |=> (rdata_out & ~32'h0000_E1D3) == 32'h0)
		else $error("control reserved bits set");
	AST_STAT_RSV: assert property (rd_in && addr_in == ACC_ADDR_STAT |=> (rdata_out & ~32'h0000_2007) == 32'h0)
		else $error("status reserved bits set");
	AST_IDLE: assert property ((stop_in_idle_q && idle_in) [*2] |-> !analog_out[0].power_on)
		else $error("comparator runs in idle");
endmodule
`default_nettype wire

//--- verification/acc_pins_model.sv
// Analog pin model: steers pin levels into raw comparator results
`timescale 1ns/1ns
`default_nettype none
module acc_pins_model
	import acc_pkg::*;
(
	input  wire acc_analog_ctl_type [2:0] analog_in, // Steering
	input  wire logic [11:0]              pins_in,   // Nibble i = d,c,b,a
	input  wire logic                     ref_in,    // Programmable level
	input  wire logic                     abs_in,    // Absolute level
	output logic [2:0]                    raw_out    // Raw results
);
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			raw_out[i] = analog_in[i].power_on
				& (analog_in[i].pos_from_reference ? ref_in : pins_in[4*i])
				& ~(analog_in[i].negative_input_select == 2'h3 ? abs_in
				: pins_in[4*i+1+analog_in[i].negative_input_select]);
		end
	end
endmodule
`default_nettype wire

//--- verification/analog_comparator_control_tb.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ns
`default_nettype none
module analog_comparator_control_tb;
	import acc_pkg::*;
	logic clk = 0, rstn = 0, wr = 0, rd = 0, idle = 0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wd = 32'h0, rdata, n;
	logic [2:0] raw, pin, oe, ev;
	logic [11:0] pins = 12'h000;
	acc_analog_ctl_type [2:0] an;
	acc_ref_ctl_type rf;
	int errors = 0, n_tests = 0;
	always #5 clk = ~clk;
	acc_top acc_top_inst (.core_clk_in(clk), .resetn_in(rstn), .addr_in(addr),
		.wdata_in(wd), .wr_in(wr), .rd_in(rd), .idle_in(idle), .raw_in(raw),
		.rdata_out(rdata), .result_pin_out(pin), .result_pin_oe_out(oe),
		.event_out(ev), .analog_out(an), .ref_ctl_out(rf));
	acc_pins_model acc_pins_model_inst (.analog_in(an), .pins_in(pins),
		.ref_in(1'b1), .abs_in(1'b0), .raw_out(raw));
	task complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", s, e, g);
			errors++;
		end
	endtask
	task wrt(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk) begin wr <= 1'b1; addr <= a; wd <= d; end
		@(posedge clk) wr <= 1'b0;
	endtask
	task rdc(input string s, input logic [3:0] a, input logic [31:0] e);
		@(posedge clk) begin rd <= 1'b1; addr <= a; end
		@(posedge clk) rd <= 1'b0;
		#1 chk(s, e, rdata);
	endtask
	task t_reset;
		rdc("control", ACC_ADDR_CMP1, 32'h0000_00C3);
		rdc("status", ACC_ADDR_STAT, 32'h0);
		rdc("ladder", ACC_ADDR_REF, 32'h0);
		$display("reset test done");
	endtask
	task t_fields;
		wrt(ACC_ADDR_CMP1, 32'hFFFF_FFFF);
		repeat (5) @(posedge clk);
		rdc("control all", ACC_ADDR_CMP1, 32'h0000_E0D3);
		rdc("unmapped", 4'h1, 32'h0);
		wrt(ACC_ADDR_REF, 32'hFFFF_FFFF);
		rdc("ladder all", ACC_ADDR_REF, 32'h0000_807F);
		chk("ladder out", 32'hFF, {24'h0, rf});
		wrt(ACC_ADDR_STAT, 32'hFFFF_FFFF);
		rdc("status all", ACC_ADDR_STAT, 32'h0000_2000);
		@(posedge clk) idle <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk("idle power", 32'h0, {31'h0, an[0].power_on});
		@(posedge clk) idle <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk("awake power", 32'h1, {31'h0, an[0].power_on});
		wrt(ACC_ADDR_STAT, 32'h0);
		$display("field test done");
	endtask
	task t_count(input int i, input logic a);
		@(posedge clk) pins[4*i] <= a;
		n = 0;
		repeat (8) begin
			@(posedge clk);
			#1 n = n + ev[i];
		end
	endtask
	task t_edges;
		logic [31:0] cw;
		for (int i = 0; i < 3; i++) begin
			for (int c = 0; c < 8; c++) begin
				cw = 32'hC000 | (c[2] << 13) | (c[1:0] << 6);
				wrt(4'(4*i), cw);
				repeat (6) @(posedge clk);
				t_count(i, 1'b1);
				chk("rise events", c[2] ? c[1] : c[0], n);
				chk("pin", {30'h0, 2'b10 | !c[2]}, {oe[i], pin[i]});
				rdc("level", 4'(4*i), cw | (c[2] ? 32'h0 : 32'h100));
				rdc("stat lvl", ACC_ADDR_STAT, c[2] ? 32'h0 : 32'h1 << i);
				t_count(i, 1'b0);
				chk("fall events", c[2] ? c[0] : c[1], n);
			end
			wrt(4'(4*i), 32'h8000);
			repeat (2) @(posedge clk);
			#1 chk("pin released", 32'h0, {31'h0, oe[i]});
			wrt(4'(4*i), 32'h0);
			repeat (2) @(posedge clk);
			rdc("off control", 4'(4*i), 32'h0);
		end
		$display("edge test done");
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		t_reset;
		t_fields;
		t_edges;
		complete_run;
	end
	initial begin
		repeat (50000) @(posedge clk);
		errors++;
		complete_run;
	end
endmodule
bind acc_top acc_top_chk #(.NUM_CMP(NUM_CMP)) acc_top_chk_inst (
	.core_clk_in(core_clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .idle_in(idle_in),
	.raw_in(raw_in), .rdata_out(rdata_out), .result_pin_out(result_pin_out),
	.result_pin_oe_out(result_pin_oe_out), .event_out(event_out),
	.analog_out(analog_out), .ref_ctl_out(ref_ctl_out));
`default_nettype wire
